// File: rtl/echo_canceller_function_control.sv
// Decided for this implementation: the register offsets and the APB slave port.
`timescale 1ns/1ns
`default_nettype none
`include "ecfc_cfg.svh"

module echo_canceller_function_control (
	input  wire logic        pclk,            // APB clock
	input  wire logic        presetn,         // Asynchronous reset, active low
	input  wire logic        psel,            // APB select
	input  wire logic        penable,         // APB enable
	input  wire logic        pwrite,          // APB direction
	input  wire logic [11:0] paddr,           // APB byte address
	input  wire logic [31:0] pwdata,          // APB write data
	output logic      [31:0] prdata,          // APB read data
	output logic             pready,          // APB ready
	output logic             pslverr,         // APB error on unmapped address
	input  wire logic        setup_strap_one, // Configuration strap 1
	input  wire logic        setup_strap_two, // Configuration strap 2
	input  wire logic        phase_reversal_strap, // Standalone reversal select
	input  wire logic        nonlinear_proc_strap, // Standalone processor enable
	input  wire logic        law_pin,         // Companding law select
	input  wire logic        format_pin,      // Code format select
	input  wire logic        tone_hit_a,      // Tone seen on path A
	input  wire logic        tone_hit_b,      // Tone seen on path B
	input  wire logic        narrowband_hit,  // Narrow-band signal present
	input  wire logic        bus_bit_clock_in, // Link bit clock pin
	input  wire logic        frame_pulse_in,  // Link frame pulse, active low
	input  wire logic        pcm_in,          // Serial PCM input
	input  wire logic [15:0] tx_word_a,       // Canceller A outgoing sample
	input  wire logic [15:0] tx_word_b,       // Canceller B outgoing sample
	output logic             pcm_out,         // Serial PCM output data
	output logic             pcm_out_oe,      // Serial PCM output enable
	output logic      [15:0] rx_word_a,       // Canceller A received sample
	output logic      [15:0] rx_word_b,       // Canceller B received sample
	output logic             rx_valid,        // Pulse: received pair ready
	output logic             host_mode,       // Host mode selected
	output logic             tone_flag_a_n,   // Tone indication A, active low
	output logic             tone_flag_b_n,   // Tone indication B, active low
	output logic             tone_detect_run, // Tone detectors running
	output logic             need_reversal,   // Detector requires phase reversal
	output logic             nonlinear_run,   // Non-linear processor running
	output logic             narrowband_run,  // Narrow-band detector running
	output logic             adapt_freeze,    // Filter adaptation frozen
	output logic             offset_filter_run, // DC removal active
	output logic             a_law,           // A-law when high, mu-law low
	output logic             itu_format       // Standard coding when high
);

	// Host control register 2 and bus mode register
	logic [7:0]              ctrl2;
	logic [7:0]              next_ctrl2;
	ecfc_pkg::bus_mode_t     bus_mode;
	ecfc_pkg::bus_mode_t     next_bus_mode;
	logic [31:0]             next_prdata;
	logic                    next_pready;
	logic                    next_pslverr;

	// Two-flop synchronisers for the pins
	logic [9:0]              sync1;
	logic [9:0]              sync2;

	// Decode of one APB address into a hit flag
	function automatic logic addr_hit(input logic [11:0] a, input logic [11:0] r);
		addr_hit = (a == r);
	endfunction

	// Synchronise every pin from outside the clock domain except tone_hit_a and tone_hit_b
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1 <= `SYNC_RESET;
			sync2 <= `SYNC_RESET;
		end else begin
			sync1 <= {setup_strap_one, setup_strap_two, phase_reversal_strap,
				nonlinear_proc_strap, law_pin, format_pin, bus_bit_clock_in,
				frame_pulse_in, pcm_in, narrowband_hit};
			sync2 <= sync1;
		end
	end

	// Synchronised pin views
	logic s_cfg1;
	logic s_cfg2;
	logic s_rev;
	logic s_nlp;
	logic s_law;
	logic s_fmt;
	logic s_bclk;
	logic s_frame_n;
	logic s_din;
	logic s_nb;
	assign {s_cfg1, s_cfg2, s_rev, s_nlp, s_law, s_fmt, s_bclk, s_frame_n, s_din, s_nb} = sync2;

	// APB slave: one wait-free access phase, unmapped reads error
	always_comb begin
		next_ctrl2    = ctrl2;
		next_bus_mode = bus_mode;
		next_prdata   = prdata;
		next_pready   = 1'b0;
		next_pslverr  = 1'b0;
		if (psel && !penable) begin
			next_pready = 1'b1;
			if (addr_hit(paddr, `ADDR_CTRL2)) begin
				next_prdata = {24'h000000, pwrite ? pwdata[7:0] : ctrl2};
			end else if (addr_hit(paddr, `ADDR_PCMCFG)) begin
				next_prdata = {30'h00000000, pwrite ? pwdata[1:0] : bus_mode};
			end else if (addr_hit(paddr, `ADDR_STATUS)) begin
				next_prdata = {24'h000000, host_mode, tone_flag_a_n, tone_flag_b_n,
					tone_detect_run, need_reversal, nonlinear_run,
					narrowband_run, offset_filter_run};
			end else begin
				next_prdata  = 32'h00000000;
				next_pslverr = 1'b1;
			end
		end
		// Writes land only at the access edge that completes the transfer
		if (psel && penable && pready && pwrite) begin
			if (addr_hit(paddr, `ADDR_CTRL2)) begin
				next_ctrl2 = pwdata[7:0];
			end
			if (addr_hit(paddr, `ADDR_PCMCFG)) begin
				next_bus_mode = ecfc_pkg::bus_mode_t'(pwdata[1:0]);
			end
		end
	end

	// Register the APB state; pready rises in the access phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl2    <= `CTRL2_RESET;
			bus_mode <= ecfc_pkg::bus_mode_t'(`PCMCFG_RESET);
			prdata   <= 32'h00000000;
			pready   <= 1'b0;
			pslverr  <= 1'b0;
		end else begin
			ctrl2    <= next_ctrl2;
			bus_mode <= next_bus_mode;
			prdata   <= next_prdata;
			pready   <= next_pready;
			pslverr  <= next_pslverr;
		end
	end

	// Function enables from host register, else from straps or fixed on
	logic next_host;
	logic next_td_run;
	logic next_rev;
	logic next_nlp;
	logic next_nb;
	logic next_hpf;
	always_comb begin
		next_host   = !s_cfg1 && !s_cfg2;
		if (next_host) begin
			next_td_run = !ctrl2[`CTRL2_TD_BIT];
			next_rev    = !ctrl2[`CTRL2_PH_BIT];
			next_nlp    = !ctrl2[`CTRL2_NLP_BIT];
			next_nb     = !ctrl2[`CTRL2_NB_BIT];
			next_hpf    = !ctrl2[`CTRL2_HPF_BIT];
		end else begin
			next_td_run = 1'b1;
			next_rev    = s_rev;
			next_nlp    = s_nlp;
			next_nb     = 1'b1;
			next_hpf    = 1'b1;
		end
	end

	// Register enables, flags and coding selections
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			host_mode         <= 1'b0;
			tone_detect_run   <= 1'b1;
			need_reversal     <= 1'b0;
			nonlinear_run     <= 1'b0;
			narrowband_run    <= 1'b1;
			offset_filter_run <= 1'b1;
			adapt_freeze      <= 1'b0;
			tone_flag_a_n     <= 1'b1;
			tone_flag_b_n     <= 1'b1;
			a_law             <= 1'b0;
			itu_format        <= 1'b0;
		end else begin
			host_mode         <= next_host;
			tone_detect_run   <= next_td_run;
			need_reversal     <= next_rev;
			nonlinear_run     <= next_nlp;
			narrowband_run    <= next_nb;
			offset_filter_run <= next_hpf;
			adapt_freeze      <= next_nb && s_nb;
			tone_flag_a_n     <= !(next_td_run && tone_hit_a);
			tone_flag_b_n     <= !(next_td_run && tone_hit_b);
			a_law             <= s_law;
			itu_format        <= s_fmt;
		end
	end

	// Link bit-clock edge detection from the synchronised copy
	logic bclk_d;
	logic bclk_rise;
	logic bclk_fall;
	assign bclk_rise = s_bclk && !bclk_d;
	assign bclk_fall = !s_bclk && bclk_d;

	// Link framing: bit counter restarts on frame pulse
	ecfc_pkg::link_state_t   lstate;
	ecfc_pkg::link_state_t   next_lstate;
	logic [7:0]              bit_cnt;
	logic [7:0]              next_bit_cnt;
	logic [15:0]             sh_in;
	logic [15:0]             next_sh_in;
	logic [15:0]             next_rx_a;
	logic [15:0]             next_rx_b;
	logic                    next_rx_valid;
	logic                    next_out;
	logic                    next_oe;

	// Slot owned by the device in the current mode
	function automatic logic slot_owned(input ecfc_pkg::bus_mode_t m,
			input logic [4:0] s);
		case (m)
			ecfc_pkg::BUS_MODE1: slot_owned = (s == `SLOT_A_M1) || (s == `SLOT_B_M1);
			ecfc_pkg::BUS_MODE2: slot_owned = (s == `SLOT_A_M2) || (s == `SLOT_B_M2);
			ecfc_pkg::BUS_MODE3: slot_owned = (s == `SLOT_A_M2) || (s == `SLOT_B_M2);
			ecfc_pkg::BUS_MODE4: slot_owned = (s <= `LIN_LAST_SLOT);
			default:             slot_owned = 1'b0;
		endcase
	endfunction

	logic [4:0] slot;
	logic       in_b;
	logic [3:0] bit_pos;
	logic [7:0] cur_cnt;
	// A falling edge inside the frame pulse is bit 0 of the frame
	assign cur_cnt = (bclk_fall && !s_frame_n) ? `ZERO_BIT : bit_cnt;
	assign slot = cur_cnt[7:`SLOT_BITS];
	assign in_b = (bus_mode == ecfc_pkg::BUS_MODE4) ? slot[1] : slot[0];
	assign bit_pos = (bus_mode == ecfc_pkg::BUS_MODE4) ?
		{slot[0], cur_cnt[2:0]} : {1'b1, cur_cnt[2:0]};

	// Shift data per bit on the link, msb first
	always_comb begin
		next_lstate   = lstate;
		next_bit_cnt  = bit_cnt;
		next_sh_in    = sh_in;
		next_rx_a     = rx_word_a;
		next_rx_b     = rx_word_b;
		next_rx_valid = 1'b0;
		next_out      = pcm_out;
		next_oe       = pcm_out_oe;
		case (lstate)
			ecfc_pkg::LINK_HUNT: begin
				next_oe = 1'b0;
				if (!s_frame_n) begin
					next_lstate  = ecfc_pkg::LINK_RUN;
					next_bit_cnt = 8'h00;
				end
			end
			ecfc_pkg::LINK_RUN: begin
				if (bclk_fall) begin
					// Frame pulse at a falling edge restarts the count
					if (!s_frame_n) begin
						next_bit_cnt = `ZERO_BIT;
					end
					// Drive the owned slot bit or release the line
					next_oe = slot_owned(bus_mode, slot);
					next_out = next_oe ? (in_b ? tx_word_b[4'hF - bit_pos]
						: tx_word_a[4'hF - bit_pos]) : 1'b0;
				end
				if (bclk_rise) begin
					if (slot_owned(bus_mode, slot)) begin
						next_sh_in = {sh_in[14:0], s_din};
						if (bit_cnt[2:0] == 3'h7 && bit_pos[3]) begin
							if (in_b) begin
								next_rx_b     = (bus_mode == ecfc_pkg::BUS_MODE4) ?
									next_sh_in : {8'h00, next_sh_in[7:0]};
								next_rx_valid = 1'b1;
							end else begin
								next_rx_a = (bus_mode == ecfc_pkg::BUS_MODE4) ?
									next_sh_in : {8'h00, next_sh_in[7:0]};
							end
						end
					end
					next_bit_cnt = bit_cnt + 8'h01;
				end
			end
			default: next_lstate = ecfc_pkg::LINK_HUNT;
		endcase
	end

	// Register the link state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bclk_d     <= 1'b1;
			lstate     <= ecfc_pkg::LINK_HUNT;
			bit_cnt    <= 8'h00;
			sh_in      <= 16'h0000;
			rx_word_a  <= 16'h0000;
			rx_word_b  <= 16'h0000;
			rx_valid   <= 1'b0;
			pcm_out    <= 1'b0;
			pcm_out_oe <= 1'b0;
		end else begin
			bclk_d     <= s_bclk;
			lstate     <= next_lstate;
			bit_cnt    <= next_bit_cnt;
			sh_in      <= next_sh_in;
			rx_word_a  <= next_rx_a;
			rx_word_b  <= next_rx_b;
			rx_valid   <= next_rx_valid;
			pcm_out    <= next_out;
			pcm_out_oe <= next_oe;
		end
	end

	// Checks on function selection and link behaviour
	AST_HOST_SEL: assert property (@(posedge pclk) disable iff (!presetn)
		$past(presetn) |-> host_mode == $past(!sync2[9] && !sync2[8])) else $error("host mode wrong");
	AST_TD_FLAG: assert property (@(posedge pclk) disable iff (!presetn)
		(!host_mode && $past(tone_hit_a) && !$past(host_mode)) |-> !tone_flag_a_n)
		else $error("tone flag a missing");
	AST_TD_OFF: assert property (@(posedge pclk) disable iff (!presetn)
		(host_mode && $past(host_mode,2) && $past(ctrl2[`CTRL2_TD_BIT])) |-> !tone_detect_run)
		else $error("tone detect not off");
	AST_NLP_STRAP: assert property (@(posedge pclk) disable iff (!presetn)
		(!host_mode && !$past(host_mode)) |-> nonlinear_run == $past(s_nlp))
		else $error("processor strap ignored");
	AST_NLP_OFF: assert property (@(posedge pclk) disable iff (!presetn)
		(host_mode && $past(host_mode)) |-> nonlinear_run == !$past(ctrl2[`CTRL2_NLP_BIT]))
		else $error("processor off bit ignored");
	AST_LAW: assert property (@(posedge pclk) disable iff (!presetn)
		a_law == $past(s_law)) else $error("law wrong");
	AST_FMT: assert property (@(posedge pclk) disable iff (!presetn)
		itu_format == $past(s_fmt)) else $error("format wrong");
	AST_NB_OFF: assert property (@(posedge pclk) disable iff (!presetn)
		(host_mode && $past(host_mode) && $past(ctrl2[`CTRL2_NB_BIT])) |-> !adapt_freeze)
		else $error("narrowband not off");
	AST_HPF: assert property (@(posedge pclk) disable iff (!presetn)
		(!host_mode && !$past(host_mode)) |-> offset_filter_run)
		else $error("offset filter off");
	AST_HIZ: assert property (@(posedge pclk) disable iff (!presetn)
		(lstate == ecfc_pkg::LINK_HUNT) |=> !pcm_out_oe) else $error("drive outside frame");
	COV_HOST: cover property (@(posedge pclk) disable iff (!presetn) host_mode);
	COV_RXV: cover property (@(posedge pclk) disable iff (!presetn) rx_valid);
	COV_TONE: cover property (@(posedge pclk) disable iff (!presetn) !tone_flag_b_n);

endmodule
`default_nettype wire

// File: rtl/ecfc_cfg.svh
`ifndef ECFC_CFG_SVH
`define ECFC_CFG_SVH
// APB register byte addresses
`define ADDR_CTRL2      12'h004
`define ADDR_STATUS     12'h008
`define ADDR_PCMCFG     12'h00C
// Control register 2 field positions
`define CTRL2_HPF_BIT   2
`define CTRL2_NB_BIT    3
`define CTRL2_NLP_BIT   5
`define CTRL2_PH_BIT    6
`define CTRL2_TD_BIT    7
`define CTRL2_RESET     8'h00
// PCM configuration register: mode field reset value
`define PCMCFG_RESET    2'h0
// Frame geometry: 32 timeslots of 8 bits
`define SLOT_BITS       3
`define SLOT_IDX_BITS   5
`define SLOT_A_M1       5'h00
`define SLOT_B_M1       5'h01
`define SLOT_A_M2       5'h02
`define SLOT_B_M2       5'h03
`define LIN_LAST_SLOT   5'h03
`define ZERO_BIT        8'h00
// Pin synchroniser reset: link clock and frame pulse at their idle high level
`define SYNC_RESET      10'h00C
`endif

// File: rtl/ecfc_pkg.sv
package ecfc_pkg;
	// TDM bus mode selection
	typedef enum logic [1:0] {
		BUS_MODE1,
		BUS_MODE2,
		BUS_MODE3,
		BUS_MODE4
	} bus_mode_t;
	// Link frame tracking
	typedef enum logic [0:0] {
		LINK_HUNT,
		LINK_RUN
	} link_state_t;
endpackage

// File: test/tdm_partner.sv
`timescale 1ns/1ns
`default_nettype none
// Far-side TDM device: runs one frame per go pulse, bit clock still between frames
module tdm_partner (
	input  wire logic        go,               // Start one frame
	input  wire logic [31:0] send_bits,        // Slots 0..3, first bit in [31]
	input  wire logic        pcm_out,          // Device serial output
	input  wire logic        pcm_out_oe,       // Device output enable
	output logic             bus_bit_clock_in, // Bit clock, 64 ns
	output logic             frame_pulse_in,   // Frame pulse, active low
	output logic             pcm_in,           // Serial data to the device
	output logic      [31:0] got_bits,         // Captured slots 0..3
	output logic      [31:0] got_oe,           // Enable seen per bit
	output logic             stray_oe,         // Enable seen after slot 3
	output logic             busy              // Frame in progress
);
	initial begin
		bus_bit_clock_in = 1'b1;
		frame_pulse_in = 1'b1;
		pcm_in = 1'b0;
		busy = 1'b0;
	end
	// One full frame of 256 bits; sampling late in the bit avoids sync skew
	always @(posedge go) begin : frame
		int i;
		busy = 1'b1;
		got_bits = 32'h0;
		got_oe = 32'h0;
		stray_oe = 1'b0;
		#3 frame_pulse_in = 1'b0;
		#16;
		for (i = 0; i < 256; i++) begin
			// Each bit opens on a falling clock edge
			bus_bit_clock_in = 1'b0;
			// Don't-care bits toggle outside slots 0..3
			pcm_in = (i < 32) ? send_bits[31 - i] : i[0];
			#16 frame_pulse_in = 1'b1;
			#16 bus_bit_clock_in = 1'b1;
			#30;
			if (i < 32) begin
				got_oe[31 - i] = pcm_out_oe;
				got_bits[31 - i] = pcm_out_oe & pcm_out;
			end else if (pcm_out_oe !== 1'b0) begin
				stray_oe = 1'b1;
			end
			#2;
		end
		// Clock rests high; released line shows the inverse of its last value
		pcm_in = ~pcm_in;
		#32 busy = 1'b0;
	end
endmodule
`default_nettype wire

// File: test/echo_canceller_function_control_bench.sv
`timescale 1ns/1ns
`default_nettype none
`include "ecfc_cfg.svh"
module echo_canceller_function_control_bench;
	logic        pclk = 1'b0;                          // 125 MHz
	logic        presetn, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;                                // Byte address
	logic [31:0] pwdata, prdata, r, send_bits, got_bits, got_oe;
	logic        e, go, busy, stray_oe, rx_valid, pcm_in, pcm_out, pcm_out_oe;
	logic        setup_strap_one, setup_strap_two, phase_reversal_strap;
	logic        nonlinear_proc_strap, law_pin, format_pin;
	logic        tone_hit_a, tone_hit_b, narrowband_hit;
	logic        bus_bit_clock_in, frame_pulse_in, host_mode, tone_flag_a_n;
	logic        tone_flag_b_n, tone_detect_run, need_reversal, nonlinear_run;
	logic        narrowband_run, adapt_freeze, offset_filter_run, a_law, itu_format;
	logic [15:0] tx_word_a, tx_word_b, rx_word_a, rx_word_b;
	int          miscompares = 0, num_checks = 0, cycles = 0, rx_count = 0;

	always #4 pclk = ~pclk;

	echo_canceller_function_control u_dut (.pclk, .presetn, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .setup_strap_one, .setup_strap_two,
		.phase_reversal_strap, .nonlinear_proc_strap, .law_pin, .format_pin, .tone_hit_a,
		.tone_hit_b, .narrowband_hit, .bus_bit_clock_in, .frame_pulse_in, .pcm_in,
		.tx_word_a, .tx_word_b, .pcm_out, .pcm_out_oe, .rx_word_a, .rx_word_b, .rx_valid,
		.host_mode, .tone_flag_a_n, .tone_flag_b_n, .tone_detect_run, .need_reversal,
		.nonlinear_run, .narrowband_run, .adapt_freeze, .offset_filter_run, .a_law,
		.itu_format);
	tdm_partner u_far (.go, .send_bits, .pcm_out, .pcm_out_oe, .bus_bit_clock_in,
		.frame_pulse_in, .pcm_in, .got_bits, .got_oe, .stray_oe, .busy);

	// Received pairs and hang guard
	always @(posedge pclk) begin
		if (rx_valid === 1'b1) rx_count++;
		cycles++;
		if (cycles == 12000) begin
			miscompares++;
			give_verdict();
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// One APB transfer; waits for pready, data taken at that edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		repeat (4) @(posedge pclk);
	endtask

	// Straps, law, format and detector events, then settle through the syncs
	task automatic pins(input logic [8:0] v);
		@(posedge pclk);
		{setup_strap_one, setup_strap_two, phase_reversal_strap, nonlinear_proc_strap,
			law_pin, format_pin, tone_hit_a, tone_hit_b, narrowband_hit} <= v;
		repeat (8) @(posedge pclk);
	endtask

	task automatic test_regs();
		apb(1'b0, `ADDR_CTRL2, 32'h0);
		check(r, `CTRL2_RESET);
		apb(1'b0, `ADDR_PCMCFG, 32'h0);
		check(r, `PCMCFG_RESET);
		apb(1'b0, 12'h010, 32'h0);
		check(r, 32'h0);
		check(e, 1'h1);
		$display("test_regs done");
	endtask

	task automatic test_standalone();
		logic [1:0] k;
		for (k = 2'h1; k != 2'h0; k++) begin
			pins({k, 7'h50});
			check(host_mode, 1'h0);
			check({need_reversal, nonlinear_run, a_law, itu_format}, 4'hA);
			check({tone_detect_run, narrowband_run, offset_filter_run}, 3'h7);
			pins({k, 7'h2F});
			check({need_reversal, nonlinear_run, a_law, itu_format}, 4'h5);
			check({tone_flag_a_n, tone_flag_b_n}, 2'h0);
			check(adapt_freeze, 1'h1);
		end
		$display("test_standalone done");
	endtask

	task automatic test_host();
		int cb[5] = '{7, 6, 5, 3, 2};
		int k;
		logic [4:0] run;
		logic [1:0] fl;
		pins(9'h00F);
		check(host_mode, 1'h1);
		for (k = 0; k < 5; k++) begin
			apb(1'b1, `ADDR_CTRL2, 32'h1 << cb[k]);
			run = 5'h1F ^ (5'h10 >> k);
			fl = (k == 0) ? 2'h3 : 2'h0;
			check({tone_detect_run, need_reversal, nonlinear_run, narrowband_run,
				offset_filter_run}, run);
			check({tone_flag_a_n, tone_flag_b_n, adapt_freeze}, {fl, k != 3});
			check({a_law, itu_format}, 2'h1);
			apb(1'b0, `ADDR_STATUS, 32'h0);
			check(r, {24'h0, 1'b1, fl, run});
		end
		apb(1'b1, `ADDR_CTRL2, 32'h0);
		$display("test_host done");
	endtask

	task automatic test_link();
		int m;
		int n;
		logic [31:0] oe_x, bits_x;
		logic [15:0] mk;
		for (m = 0; m < 4; m++) begin
			apb(1'b1, `ADDR_PCMCFG, m);
			send_bits <= 32'hC3A55A3C ^ {4{m[7:0]}};
			tx_word_a <= 16'h9A17 + m[15:0];
			tx_word_b <= 16'h6E81 - m[15:0];
			n = rx_count;
			@(posedge pclk);
			go <= 1'b1;
			@(posedge pclk);
			go <= 1'b0;
			repeat (3000) begin
				@(posedge pclk);
				if (busy === 1'b0) break;
			end
			repeat (8) @(posedge pclk);
			oe_x = (m == 3) ? 32'hFFFFFFFF : (m == 0) ? 32'hFFFF0000 : 32'h0000FFFF;
			bits_x = (m == 3) ? {tx_word_a, tx_word_b} : {2{tx_word_a[7:0], tx_word_b[7:0]}};
			mk = (m == 3) ? 16'hFFFF : 16'h00FF;
			check({got_oe, stray_oe}, {oe_x, 1'b0});
			check(got_bits, bits_x & oe_x);
			check(rx_count, n + 1);
			if (m == 0) begin
				check({rx_word_a & mk, rx_word_b & mk}, {8'h0, send_bits[31:24],
					8'h0, send_bits[23:16]});
			end else if (m == 3) begin
				check({rx_word_a, rx_word_b}, send_bits);
			end else begin
				check({rx_word_a & mk, rx_word_b & mk}, {8'h0, send_bits[15:8],
					8'h0, send_bits[7:0]});
			end
		end
		$display("test_link done");
	endtask

	task automatic give_verdict();
		$display("Checks %0d, mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	initial begin
		{presetn, psel, penable, pwrite, go, tone_hit_a, tone_hit_b, narrowband_hit} = 8'h0;
		{setup_strap_one, setup_strap_two, phase_reversal_strap} = 3'h6;
		{nonlinear_proc_strap, law_pin, format_pin} = 3'h0;
		{paddr, pwdata, send_bits, tx_word_a, tx_word_b} = 108'h0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		test_regs();
		test_standalone();
		test_host();
		test_link();
		give_verdict();
	end
endmodule
`default_nettype wire
